/* File: core/ahbx_pkg.sv */
// Purpose: shared constants and types for the ahb-lite to axi bridge
// Assumes: one clock, synchronous active-high reset
// Notes: digest of the block's behaviour follows
// What this block does
// RULE_01: fixed-length reads stay fixed-length axi bursts
// RULE_02: fixed writes answer only on last beat
// RULE_03: undefined-length reads become axi singles
// RULE_04: undefined-length writes: singles, each beat waits for its own b response
// RULE_05: read/write overrides exist only with promotion/broken
// RULE_06: read override forces every read to singles
// RULE_07: write override forces every write to singles
// RULE_08: overrides written through the config register port
// RULE_09: abandoned read burst stalls master until drained
// RULE_10: write bursts are never cut short
// RULE_11: master locks only as read-then-write swap pairs
// RULE_12: next unlocking transaction releases a stalled path
// RULE_13: lock override suppresses axi locks when present
// RULE_14: secure mode marks all traffic secure
// RULE_15: non-secure mode marks all traffic non-secure
// RULE_16: address user goes to aw or ar by direction
// RULE_17: write user to wuser, ruser back to hruser
// RULE_18: address 32-64 bits, data 32-256 bits
// RULE_19: lock support is an optional build choice
// RULE_20: all override bits reset cleared
// RULE_21: per-access mode takes security from the I_HNONSEC input
package ahbx_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int USER_W = 8;
	localparam logic [1:0] TR_BUSY = 2'h1;
	localparam logic [1:0] TR_NSEQ = 2'h2;
	localparam logic [2:0] HB_INCR = 3'h1;
	localparam logic [2:0] HB_INCR8 = 3'h5;
	localparam logic [1:0] AX_INCR = 2'h1;
	localparam logic [1:0] AX_WRAP = 2'h2;
	localparam logic [7:0] LEN1 = 8'h00;
	localparam logic [7:0] LEN4 = 8'h03;
	localparam logic [7:0] LEN8 = 8'h07;
	localparam logic [7:0] LEN16 = 8'h0f;
	localparam int CFG_W = 3;
	localparam int CFG_RD_OVR = 0;
	localparam int CFG_WR_OVR = 1;
	localparam int CFG_LOCK_OVR = 2;
	localparam logic [2:0] CFG_RST = 3'h0;
	localparam logic [1:0] SEC_SECURE = 2'h0;
	localparam logic [1:0] SEC_NONSEC = 2'h1;
	localparam logic [1:0] SEC_PER_ACC = 2'h2;
	typedef enum logic [3:0] {ST_IDLE, ST_AR, ST_R, ST_AW, ST_W, ST_B, ST_ERR1, ST_ERR2, ST_DRAIN} ahbx_state_type;
endpackage

/* File: core/ahbx_cfg_if.sv */
// Purpose: override bits from the config block to the bridge core
// Assumes: same clock on both sides
// Notes: bits are already gated by what the build includes
`timescale 1ns/1ns
`default_nettype none
interface ahbx_cfg_if;
	logic rd_ovr;
	logic wr_ovr;
	logic lock_ovr;
	modport cfg (output rd_ovr, output wr_ovr, output lock_ovr);
	modport core (input rd_ovr, input wr_ovr, input lock_ovr);
endinterface
`default_nettype wire

/* File: core/ahbx_cfg.sv */
// Purpose: config register port holding the override bits
// Assumes: writer sits on the bridge clock
// Notes: bits not built read as zero and cannot be set
`timescale 1ns/1ns
`default_nettype none
module ahbx_cfg #(
	parameter bit P_OVR_EN = 1'b0,
	parameter bit P_LOCK_OVR_EN = 1'b1
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// register port
	input wire logic i_we,
	input wire logic [ahbx_pkg::CFG_W-1:0] i_wdata,
	output logic [ahbx_pkg::CFG_W-1:0] o_rdata,
	// to the core
	ahbx_cfg_if.cfg cfg
);
	logic [ahbx_pkg::CFG_W-1:0] cfg_q;
	logic [ahbx_pkg::CFG_W-1:0] cfg_d;
	logic [ahbx_pkg::CFG_W-1:0] impl;

	always_comb
	begin
		impl = '0;
		impl[ahbx_pkg::CFG_RD_OVR] = P_OVR_EN; // [RULE_05]
		impl[ahbx_pkg::CFG_WR_OVR] = P_OVR_EN; // [RULE_05]
		impl[ahbx_pkg::CFG_LOCK_OVR] = P_LOCK_OVR_EN; // [RULE_13]
		cfg_d = cfg_q;
		if (i_we)
			cfg_d = i_wdata & impl; // [RULE_08]
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			cfg_q <= ahbx_pkg::CFG_RST; // [RULE_20]
		else
			cfg_q <= cfg_d;
	end

	assign o_rdata = cfg_q;
	assign cfg.rd_ovr = cfg_q[ahbx_pkg::CFG_RD_OVR];
	assign cfg.wr_ovr = cfg_q[ahbx_pkg::CFG_WR_OVR];
	assign cfg.lock_ovr = cfg_q[ahbx_pkg::CFG_LOCK_OVR];

	a_cfg_reset_clear: assert property (@(posedge i_clk) $past(i_rst) |-> cfg_q == 3'h0) // [RULE_20]
		else $error("override bits not clear after reset");
	a_ovr_absent: assert property (@(posedge i_clk) disable iff (i_rst)
		!P_OVR_EN |-> !cfg_q[ahbx_pkg::CFG_RD_OVR] && !cfg_q[ahbx_pkg::CFG_WR_OVR]) // [RULE_05]
		else $error("override bit set though not built");
	a_cfg_write_takes: assert property (@(posedge i_clk) disable iff (i_rst)
		i_we && P_OVR_EN |=> o_rdata[ahbx_pkg::CFG_RD_OVR] == $past(i_wdata[ahbx_pkg::CFG_RD_OVR])) // [RULE_08]
		else $error("config write did not land");
endmodule
`default_nettype wire

/* File: core/ahbx_burst_dec.sv */
// Purpose: ahb burst kind to axi length and burst type
// Assumes: single and undefined-length incr map to one beat
// Notes: purely combinational
`timescale 1ns/1ns
`default_nettype none
module ahbx_burst_dec (
	// request
	input wire logic [2:0] i_hburst,
	input wire logic i_single,
	// result
	output logic [7:0] o_len,
	output logic [1:0] o_burst
);
	always_comb
	begin
		o_len = ahbx_pkg::LEN1; // [RULE_03] [RULE_04]
		o_burst = ahbx_pkg::AX_INCR;
		if (!i_single) // [RULE_06] [RULE_07]
		begin
			case (i_hburst[2:1])
				2'h1: o_len = ahbx_pkg::LEN4; // [RULE_01]
				2'h2: o_len = ahbx_pkg::LEN8;
				2'h3: o_len = ahbx_pkg::LEN16;
				default: o_len = ahbx_pkg::LEN1;
			endcase
			if (!i_hburst[0] && i_hburst[2:1] != 2'h0)
				o_burst = ahbx_pkg::AX_WRAP;
		end
	end
endmodule
`default_nettype wire

/* File: core/ahbx_bridge.sv */
// Purpose: ahb-lite slave port turned into axi transactions
// Assumes: one transaction outstanding, no buffering, one clock
// Notes: behaves as the default conversion; overrides add singles
`timescale 1ns/1ns
`default_nettype none
module ahbx_bridge #(
	parameter int P_ADDR_W = ahbx_pkg::ADDR_W,
	parameter int P_DATA_W = ahbx_pkg::DATA_W,
	parameter bit P_INCR_PROMO = 1'b0,
	parameter bit P_BROKEN = 1'b0,
	parameter bit P_LOCK_EN = 1'b1,
	parameter bit P_CFG_PORT = 1'b1,
	parameter logic [1:0] P_SEC_MODE = ahbx_pkg::SEC_SECURE
) (
	// clock and reset
	input wire logic I_CLK_SYS,
	input wire logic I_RST,
	// ahb-lite slave
	input wire logic I_HSEL,
	input wire logic [P_ADDR_W-1:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [2:0] I_HSIZE,
	input wire logic [2:0] I_HBURST,
	input wire logic [3:0] I_HPROT,
	input wire logic I_HMASTLOCK,
	input wire logic I_HNONSEC,
	input wire logic [ahbx_pkg::USER_W-1:0] I_HAUSER,
	input wire logic [P_DATA_W-1:0] I_HWDATA,
	input wire logic [ahbx_pkg::USER_W-1:0] I_HWUSER,
	input wire logic I_HREADY,
	output logic O_HREADYOUT,
	output logic O_HRESP,
	output logic [P_DATA_W-1:0] O_HRDATA,
	output logic [ahbx_pkg::USER_W-1:0] O_HRUSER,
	// axi write address
	output logic O_AWVALID,
	input wire logic I_AWREADY,
	output logic [P_ADDR_W-1:0] O_AWADDR,
	output logic [7:0] O_AWLEN,
	output logic [2:0] O_AWSIZE,
	output logic [1:0] O_AWBURST,
	output logic O_AWLOCK,
	output logic [2:0] O_AWPROT,
	output logic [ahbx_pkg::USER_W-1:0] O_AWUSER,
	// axi write data
	output logic O_WVALID,
	input wire logic I_WREADY,
	output logic [P_DATA_W-1:0] O_WDATA,
	output logic [P_DATA_W/8-1:0] O_WSTRB,
	output logic O_WLAST,
	output logic [ahbx_pkg::USER_W-1:0] O_WUSER,
	// axi write response
	input wire logic I_BVALID,
	output logic O_BREADY,
	input wire logic [1:0] I_BRESP,
	// axi read address
	output logic O_ARVALID,
	input wire logic I_ARREADY,
	output logic [P_ADDR_W-1:0] O_ARADDR,
	output logic [7:0] O_ARLEN,
	output logic [2:0] O_ARSIZE,
	output logic [1:0] O_ARBURST,
	output logic O_ARLOCK,
	output logic [2:0] O_ARPROT,
	output logic [ahbx_pkg::USER_W-1:0] O_ARUSER,
	// axi read data
	input wire logic I_RVALID,
	output logic O_RREADY,
	input wire logic [P_DATA_W-1:0] I_RDATA,
	input wire logic [1:0] I_RRESP,
	input wire logic [ahbx_pkg::USER_W-1:0] I_RUSER,
	// config register port
	input wire logic I_CFG_WE,
	input wire logic [ahbx_pkg::CFG_W-1:0] I_CFG_WDATA,
	output logic [ahbx_pkg::CFG_W-1:0] O_CFG_RDATA,
	// status
	output logic O_LOCK_HELD
);
	localparam int SB = P_DATA_W / 8;

	ahbx_pkg::ahbx_state_type st_q;
	ahbx_pkg::ahbx_state_type st_d;
	logic [P_ADDR_W-1:0] addr_q;
	logic [P_ADDR_W-1:0] addr_d;
	logic [2:0] size_q;
	logic [2:0] size_d;
	logic wr_q;
	logic wr_d;
	logic lock_q;
	logic lock_d;
	logic [2:0] prot_q;
	logic [2:0] prot_d;
	logic [ahbx_pkg::USER_W-1:0] auser_q;
	logic [ahbx_pkg::USER_W-1:0] auser_d;
	logic [7:0] len_q;
	logic [7:0] len_d;
	logic [1:0] burst_q;
	logic [1:0] burst_d;
	logic [7:0] beats_q;
	logic [7:0] beats_d;
	logic [7:0] drain_q;
	logic [7:0] drain_d;
	logic need_a_q;
	logic need_a_d;
	logic pend_q;
	logic pend_d;
	logic [P_DATA_W-1:0] rdata_q;
	logic [P_DATA_W-1:0] rdata_d;
	logic [ahbx_pkg::USER_W-1:0] ruser_q;
	logic [ahbx_pkg::USER_W-1:0] ruser_d;
	logic [P_DATA_W-1:0] wdata_q;
	logic [P_DATA_W-1:0] wdata_d;
	logic [ahbx_pkg::USER_W-1:0] wuser_q;
	logic [ahbx_pkg::USER_W-1:0] wuser_d;
	logic [SB-1:0] strb_q;
	logic [SB-1:0] strb_d;
	logic held_q;
	logic held_d;
	logic take;
	logic open_ph;
	logic fresh;
	logic nonsec;
	logic axlock;
	logic [7:0] dec_len;
	logic [1:0] dec_burst;

	ahbx_cfg_if cfg_if ();

	ahbx_cfg #(
		.P_OVR_EN(P_INCR_PROMO || P_BROKEN),
		.P_LOCK_OVR_EN(P_LOCK_EN && P_CFG_PORT)
	) u_cfg (
		.i_clk(I_CLK_SYS),
		.i_rst(I_RST),
		.i_we(I_CFG_WE),
		.i_wdata(I_CFG_WDATA),
		.o_rdata(O_CFG_RDATA),
		.cfg(cfg_if)
	);

	ahbx_burst_dec u_dec (
		.i_hburst(I_HBURST),
		.i_single(I_HWRITE ? cfg_if.wr_ovr : cfg_if.rd_ovr), // [RULE_06] [RULE_07]
		.o_len(dec_len),
		.o_burst(dec_burst)
	);

	// byte i is written when it falls inside the sized, aligned lane
	function automatic logic [SB-1:0] strb_of(input logic [2:0] sz, input logic [4:0] a);
		logic [SB-1:0] m;
		int lo;
		m = '0;
		lo = int'(a) % SB;
		for (int i = 0; i < SB; i++)
			m[i] = ((i >> sz) == (lo >> sz));
		return m;
	endfunction

	assign open_ph = (st_q == ahbx_pkg::ST_IDLE) || (st_q == ahbx_pkg::ST_ERR2);
	assign take = I_HSEL && I_HREADY && I_HTRANS[1];
	assign fresh = (I_HTRANS == ahbx_pkg::TR_NSEQ) || (beats_q == 8'h00);
	assign nonsec = (P_SEC_MODE == ahbx_pkg::SEC_PER_ACC) ? I_HNONSEC : // [RULE_21]
		(P_SEC_MODE == ahbx_pkg::SEC_NONSEC); // [RULE_14] [RULE_15]
	assign axlock = P_LOCK_EN && lock_q && !cfg_if.lock_ovr; // [RULE_13] [RULE_19]

	always_comb
	begin
		st_d = st_q;
		addr_d = addr_q;
		size_d = size_q;
		wr_d = wr_q;
		lock_d = lock_q;
		prot_d = prot_q;
		auser_d = auser_q;
		len_d = len_q;
		burst_d = burst_q;
		beats_d = beats_q;
		drain_d = drain_q;
		need_a_d = need_a_q;
		pend_d = pend_q;
		rdata_d = rdata_q;
		ruser_d = ruser_q;
		wdata_d = wdata_q;
		wuser_d = wuser_q;
		strb_d = strb_q;
		held_d = held_q;
		case (st_q)
			ahbx_pkg::ST_IDLE: st_d = ahbx_pkg::ST_IDLE;
			ahbx_pkg::ST_AR:
				if (I_ARREADY)
					st_d = ahbx_pkg::ST_R;
			ahbx_pkg::ST_R:
				if (I_RVALID)
				begin
					rdata_d = I_RDATA;
					ruser_d = I_RUSER; // [RULE_17]
					st_d = I_RRESP[1] ? ahbx_pkg::ST_ERR1 : ahbx_pkg::ST_IDLE;
				end
			ahbx_pkg::ST_AW:
			begin
				// hwdata is stable for the whole stretched data phase
				wdata_d = I_HWDATA;
				wuser_d = I_HWUSER; // [RULE_17]
				if (!need_a_q || I_AWREADY)
				begin
					need_a_d = 1'b0;
					st_d = ahbx_pkg::ST_W;
				end
			end
			ahbx_pkg::ST_W:
				// early beats complete okay, last waits for the one b answer
				if (I_WREADY)
					st_d = O_WLAST ? ahbx_pkg::ST_B : ahbx_pkg::ST_IDLE; // [RULE_02] [RULE_10]
			ahbx_pkg::ST_B:
				if (I_BVALID)
					st_d = I_BRESP[1] ? ahbx_pkg::ST_ERR1 : ahbx_pkg::ST_IDLE; // [RULE_02] [RULE_04]
			ahbx_pkg::ST_ERR1: st_d = ahbx_pkg::ST_ERR2;
			ahbx_pkg::ST_ERR2:
			begin
				st_d = ahbx_pkg::ST_IDLE;
				// read burst dropped after error: swallow the rest of it
				if (!take && I_HTRANS != ahbx_pkg::TR_BUSY && beats_q != 8'h00 && !wr_q)
				begin
					drain_d = beats_q; // [RULE_09]
					beats_d = 8'h00;
					pend_d = 1'b0;
					st_d = ahbx_pkg::ST_DRAIN;
				end
			end
			ahbx_pkg::ST_DRAIN:
				if (I_RVALID)
				begin
					drain_d = drain_q - 8'h01;
					if (drain_q == 8'h01) // [RULE_09]
					begin
						if (!pend_q)
							st_d = ahbx_pkg::ST_IDLE;
						else
							st_d = wr_q ? ahbx_pkg::ST_AW : ahbx_pkg::ST_AR;
					end
				end
			default: st_d = ahbx_pkg::ST_IDLE;
		endcase
		if (open_ph && take)
		begin
			addr_d = I_HADDR;
			size_d = I_HSIZE;
			wr_d = I_HWRITE;
			lock_d = I_HMASTLOCK;
			prot_d = {~I_HPROT[0], nonsec, I_HPROT[1]};
			auser_d = I_HAUSER; // [RULE_16]
			strb_d = strb_of(I_HSIZE, I_HADDR[4:0]);
			if (fresh)
			begin
				len_d = dec_len; // [RULE_01] [RULE_03]
				burst_d = dec_burst;
				beats_d = dec_len;
				need_a_d = 1'b1;
			end
			else
			begin
				beats_d = beats_q - 8'h01;
				need_a_d = 1'b0;
			end
			if (fresh && beats_q != 8'h00 && !wr_q)
			begin
				// new transfer waits behind the unread beats
				drain_d = beats_q; // [RULE_09]
				pend_d = 1'b1;
				st_d = ahbx_pkg::ST_DRAIN;
			end
			else if (I_HWRITE)
				st_d = ahbx_pkg::ST_AW;
			else
				st_d = fresh ? ahbx_pkg::ST_AR : ahbx_pkg::ST_R;
		end
		// a lock stall ends with the next unlocking transaction
		if ((O_ARVALID && I_ARREADY) || (O_AWVALID && I_AWREADY))
			held_d = axlock; // [RULE_11] [RULE_12]
	end

	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_RST)
		begin
			st_q <= ahbx_pkg::ST_IDLE;
			addr_q <= '0;
			size_q <= 3'h0;
			wr_q <= 1'b0;
			lock_q <= 1'b0;
			prot_q <= 3'h0;
			auser_q <= '0;
			len_q <= 8'h00;
			burst_q <= ahbx_pkg::AX_INCR;
			beats_q <= 8'h00;
			drain_q <= 8'h00;
			need_a_q <= 1'b0;
			pend_q <= 1'b0;
			rdata_q <= '0;
			ruser_q <= '0;
			wdata_q <= '0;
			wuser_q <= '0;
			strb_q <= '0;
			held_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			addr_q <= addr_d;
			size_q <= size_d;
			wr_q <= wr_d;
			lock_q <= lock_d;
			prot_q <= prot_d;
			auser_q <= auser_d;
			len_q <= len_d;
			burst_q <= burst_d;
			beats_q <= beats_d;
			drain_q <= drain_d;
			need_a_q <= need_a_d;
			pend_q <= pend_d;
			rdata_q <= rdata_d;
			ruser_q <= ruser_d;
			wdata_q <= wdata_d;
			wuser_q <= wuser_d;
			strb_q <= strb_d;
			held_q <= held_d;
		end
	end

	// idle data phases are answered at once; drain holds the bus low
	assign O_HREADYOUT = open_ph; // [RULE_09]
	assign O_HRESP = (st_q == ahbx_pkg::ST_ERR1) || (st_q == ahbx_pkg::ST_ERR2);
	assign O_HRDATA = rdata_q;
	assign O_HRUSER = ruser_q;
	assign O_AWVALID = (st_q == ahbx_pkg::ST_AW) && need_a_q;
	assign O_AWADDR = addr_q;
	assign O_AWLEN = len_q;
	assign O_AWSIZE = size_q;
	assign O_AWBURST = burst_q;
	assign O_AWLOCK = axlock;
	assign O_AWPROT = prot_q;
	assign O_AWUSER = wr_q ? auser_q : '0; // [RULE_16]
	assign O_WVALID = (st_q == ahbx_pkg::ST_W);
	assign O_WDATA = wdata_q;
	assign O_WSTRB = strb_q;
	assign O_WLAST = (beats_q == 8'h00);
	assign O_WUSER = wuser_q;
	assign O_BREADY = (st_q == ahbx_pkg::ST_B);
	assign O_ARVALID = (st_q == ahbx_pkg::ST_AR);
	assign O_ARADDR = addr_q;
	assign O_ARLEN = len_q;
	assign O_ARSIZE = size_q;
	assign O_ARBURST = burst_q;
	assign O_ARLOCK = axlock;
	assign O_ARPROT = prot_q;
	assign O_ARUSER = wr_q ? '0 : auser_q; // [RULE_16]
	assign O_RREADY = (st_q == ahbx_pkg::ST_R) || (st_q == ahbx_pkg::ST_DRAIN);
	assign O_LOCK_HELD = held_q;

	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (I_RST);

	a_rd_fixed_len: assert property (open_ph && take && !I_HWRITE && I_HTRANS == ahbx_pkg::TR_NSEQ // [RULE_01]
		&& I_HBURST == ahbx_pkg::HB_INCR8 && !cfg_if.rd_ovr && beats_q == 8'h00
		|=> O_ARVALID && O_ARLEN == 8'h07 && O_ARBURST == ahbx_pkg::AX_INCR)
		else $error("fixed read burst lost its length");
	a_rd_incr_single: assert property (open_ph && take && !I_HWRITE && I_HTRANS == ahbx_pkg::TR_NSEQ // [RULE_03]
		&& I_HBURST == ahbx_pkg::HB_INCR && beats_q == 8'h00 |=> O_ARVALID && O_ARLEN == 8'h00)
		else $error("incr read not split into singles");
	a_rd_ovr_single: assert property (open_ph && take && !I_HWRITE && cfg_if.rd_ovr // [RULE_06]
		&& beats_q == 8'h00 |=> O_ARLEN == 8'h00)
		else $error("read override ignored");
	a_wr_ovr_single: assert property (open_ph && take && I_HWRITE && cfg_if.wr_ovr // [RULE_07]
		&& beats_q == 8'h00 |=> O_AWVALID && O_AWLEN == 8'h00)
		else $error("write override ignored");
	a_wr_early_ok: assert property (st_q == ahbx_pkg::ST_W && I_WREADY && !O_WLAST // [RULE_02]
		|=> O_HREADYOUT && !O_HRESP)
		else $error("early write beat not completed okay");
	a_wr_last_err: assert property (st_q == ahbx_pkg::ST_B && I_BVALID && I_BRESP[1] // [RULE_04]
		|=> !O_HREADYOUT && O_HRESP ##1 O_HREADYOUT && O_HRESP)
		else $error("write error not returned in two cycles");
	a_drain_stall: assert property (st_q == ahbx_pkg::ST_DRAIN |-> !O_HREADYOUT && O_RREADY) // [RULE_09]
		else $error("master not stalled while draining");
	a_no_lock_ovr: assert property (cfg_if.lock_ovr |-> !O_ARLOCK && !O_AWLOCK) // [RULE_13]
		else $error("locked transfer under lock override");
	a_lock_release: assert property (O_ARVALID && I_ARREADY && !O_ARLOCK |=> !O_LOCK_HELD) // [RULE_12]
		else $error("unlocking read did not release path");
	a_sec_prot: assert property (open_ph && take |=> O_ARPROT[1] == // [RULE_14] [RULE_15] [RULE_21]
		((P_SEC_MODE == ahbx_pkg::SEC_PER_ACC) ? $past(I_HNONSEC) : (P_SEC_MODE == ahbx_pkg::SEC_NONSEC)))
		else $error("security marking wrong");
	a_user_route: assert property (open_ph && take && I_HWRITE // [RULE_16]
		|=> O_AWUSER == $past(I_HAUSER) && O_ARUSER == '0)
		else $error("address user sent to wrong channel");
	a_ruser_back: assert property (st_q == ahbx_pkg::ST_R && I_RVALID |=> O_HRUSER == $past(I_RUSER)) // [RULE_17]
		else $error("read user not returned");
	a_width_legal: assert property (P_ADDR_W >= 32 && P_ADDR_W <= 64 && (P_DATA_W == 32 // [RULE_18]
		|| P_DATA_W == 64 || P_DATA_W == 128 || P_DATA_W == 256))
		else $error("illegal bus width");
endmodule
`default_nettype wire

/* File: verif/ahbx_axi_slave.sv */
// Purpose: behavioural axi network slave facing the bridge
// Assumes: one transaction outstanding, same clock as the bridge
// Notes: stall input throttles every ready and the read valid it raises, not bvalid
`timescale 1ns/1ns
`default_nettype none
module ahbx_axi_slave (
	// clock and control
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_stall,
	input wire logic i_berr,
	// read side
	input wire logic i_arvalid,
	input wire logic [31:0] i_araddr,
	input wire logic [7:0] i_arlen,
	input wire logic i_rready,
	output logic o_arready,
	output logic o_rvalid,
	output logic [31:0] o_rdata,
	output logic [7:0] o_ruser,
	// write side
	input wire logic i_awvalid,
	input wire logic i_wvalid,
	input wire logic i_wlast,
	input wire logic i_bready,
	output logic o_awready,
	output logic o_wready,
	output logic o_bvalid,
	output logic [1:0] o_bresp
);
	logic [8:0] left_q;
	logic [31:0] addr_q;
	assign o_arready = !i_stall && left_q == 9'h0;
	assign o_awready = !i_stall;
	assign o_wready = !i_stall;
	// idle bus shows the inverse so stale data cannot pass
	assign o_rdata = o_rvalid ? addr_q : ~addr_q;
	assign o_ruser = o_rvalid ? (addr_q[7:0] ^ 8'h5a) : ~addr_q[7:0];
	assign o_bresp = o_bvalid ? {i_berr, 1'b0} : 2'h1;
	always @(posedge i_clk)
	begin
		if (i_rst)
		begin
			left_q <= 9'h0;
			addr_q <= 32'h0;
			o_rvalid <= 1'b0;
			o_bvalid <= 1'b0;
		end
		else
		begin
			if (i_arvalid && o_arready)
			begin
				left_q <= {1'b0, i_arlen} + 9'h1;
				addr_q <= i_araddr;
			end
			if (o_rvalid && i_rready)
			begin
				o_rvalid <= 1'b0;
				left_q <= left_q - 9'h1;
				addr_q <= addr_q + 32'h1;
			end
			else if (!o_rvalid && left_q != 9'h0 && !i_stall)
				o_rvalid <= 1'b1;
			if (i_wvalid && o_wready && i_wlast)
				o_bvalid <= 1'b1;
			else if (o_bvalid && i_bready)
				o_bvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: verif/ahbx_bridge_bench.sv */
// Purpose: self-checking bench for the ahb-lite to axi bridge
// Assumes: overrides built in, secure mode, 50 MHz clock
// Notes: ahb master lives in tasks, axi side in the partner
`timescale 1ns/1ns
`default_nettype none
module ahbx_bridge_bench;
	logic clk, rst, hwrite, hlock, hro, hresp, stall, berr, cfg_we, held;
	logic [1:0] htrans, bresp;
	logic [2:0] hburst, cfg_wd, cfg_rd, awprot, arprot;
	logic [31:0] haddr, hwdata, hrdata, araddr, rdata, wdata, a, wd, rd, awaddr, aw_addr;
	logic [7:0] hauser, hwuser, hruser, awlen, arlen, awuser, aruser, wuser, ruser, ru;
	logic awv, awr, wv, wr, wlast, bv, br, arv, arr, rv, rr, awlock, arlock, rs;
	logic [7:0] ar_len, aw_len, ar_user, aw_user, w_user;
	logic [2:0] ar_prot, aw_prot;
	logic [31:0] w_data;
	logic ar_lock, aw_lock;
	logic [3:0] hprot, wstrb, w_strb;
	logic [1:0] rresp, arburst, ar_burst;
	logic hns;
	int ar_cnt, aw_cnt, early, failures, total_checks, c0;
	int seed = 32'h07a40a11;
	ahbx_bridge #(.P_INCR_PROMO(1'b1)) u_dut (.I_CLK_SYS(clk), .I_RST(rst),
		.I_HSEL(1'b1), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
		.I_HBURST(hburst), .I_HPROT(hprot), .I_HMASTLOCK(hlock), .I_HNONSEC(hns), .I_HAUSER(hauser),
		.I_HWDATA(hwdata), .I_HWUSER(hwuser), .I_HREADY(hro), .O_HREADYOUT(hro), .O_HRESP(hresp),
		.O_HRDATA(hrdata), .O_HRUSER(hruser), .O_AWVALID(awv), .I_AWREADY(awr), .O_AWADDR(awaddr),
		.O_AWLEN(awlen), .O_AWSIZE(), .O_AWBURST(), .O_AWLOCK(awlock), .O_AWPROT(awprot),
		.O_AWUSER(awuser), .O_WVALID(wv), .I_WREADY(wr), .O_WDATA(wdata), .O_WSTRB(wstrb), .O_WLAST(wlast),
		.O_WUSER(wuser), .I_BVALID(bv), .O_BREADY(br), .I_BRESP(bresp), .O_ARVALID(arv),
		.I_ARREADY(arr), .O_ARADDR(araddr), .O_ARLEN(arlen), .O_ARSIZE(), .O_ARBURST(arburst),
		.O_ARLOCK(arlock), .O_ARPROT(arprot), .O_ARUSER(aruser), .I_RVALID(rv), .O_RREADY(rr),
		.I_RDATA(rdata), .I_RRESP(rresp), .I_RUSER(ruser), .I_CFG_WE(cfg_we), .I_CFG_WDATA(cfg_wd),
		.O_CFG_RDATA(cfg_rd), .O_LOCK_HELD(held));
	ahbx_axi_slave u_net (.i_clk(clk), .i_rst(rst), .i_stall(stall), .i_berr(berr),
		.i_arvalid(arv), .i_araddr(araddr), .i_arlen(arlen), .i_rready(rr), .o_arready(arr),
		.o_rvalid(rv), .o_rdata(rdata), .o_ruser(ruser), .i_awvalid(awv), .i_wvalid(wv),
		.i_wlast(wlast), .i_bready(br), .o_awready(awr), .o_wready(wr), .o_bvalid(bv), .o_bresp(bresp));
	always #10 clk = ~clk;
	// random back-pressure from the network side
	always @(negedge clk)
		stall = ($random(seed) & 3) == 0;
	always @(posedge clk)
	begin
		if (arv && arr)
		begin
			ar_cnt++;
			ar_len = arlen;
			ar_lock = arlock;
			ar_prot = arprot;
			ar_user = aruser;
			ar_burst = arburst;
		end
		if (awv && awr)
		begin
			aw_cnt++;
			aw_len = awlen;
			aw_user = awuser;
			aw_addr = awaddr;
			aw_prot = awprot;
			aw_lock = awlock;
		end
		if (wv && wr)
		begin
			w_data = wdata;
			w_strb = wstrb;
			w_user = wuser;
		end
	end
	function automatic logic [7:0] exp_ruser(input logic [31:0] ad);
		return ad[7:0] ^ 8'h5a;
	endfunction
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wait_rdy();
		int k;
		for (k = 0; k < 200 && hro !== 1'b1; k++)
			@(negedge clk);
		if (hro !== 1'b1)
		begin
			failures++;
			finish_test();
		end
	endtask
	// one ahb transfer of n beats, address and data phases pipelined
	task automatic xfer(input logic w, input logic [2:0] bu, input int n, input logic lk);
		int i;
		for (i = 0; i <= n; i++)
		begin
			if (i > 0)
				hwdata = wd + i - 1;
			htrans = (i == n) ? 2'h0 : ((i == 0) ? ahbx_pkg::TR_NSEQ : 2'h3);
			haddr = a + 4 * i;
			hwrite = w;
			hburst = bu;
			hlock = lk;
			wait_rdy();
			if (i > 0 && i < n && hresp === 1'b1)
				early++;
			rd = hrdata;
			ru = hruser;
			rs = hresp;
			@(negedge clk);
		end
	endtask
	task automatic pick();
		a = $random(seed) & 32'hffffffc0;
		wd = $random(seed);
		hauser = 8'($random(seed));
		hwuser = 8'($random(seed));
		hprot = 4'($random(seed));
		hns = 1'($random(seed));
		early = 0;
	endtask
	task automatic burst(input logic w, input logic [2:0] bu, input int n, input int ec, input logic [7:0] el);
		c0 = w ? aw_cnt : ar_cnt;
		pick();
		xfer(w, bu, n, 1'b0);
		chk("addr_count", ec, (w ? aw_cnt : ar_cnt) - c0);
		chk("axlen", el, w ? aw_len : ar_len);
	endtask
	task automatic cfg(input logic [2:0] v);
		cfg_we = 1'b1;
		cfg_wd = v;
		@(negedge clk);
		cfg_we = 1'b0;
		@(negedge clk);
		chk("cfg_rdata", v, cfg_rd);
	endtask
	initial
	begin
		clk = 0;
		rst = 1;
		{htrans, hwrite, hburst, hlock, haddr, hauser, hwdata, hwuser, hprot, hns} = '0;
		{cfg_we, cfg_wd, berr, stall, rresp, ar_cnt, aw_cnt, failures, total_checks} = '0;
		repeat (6) @(negedge clk);
		rst = 0;
		chk("cfg_rdata", 0, cfg_rd);
		chk("hreadyout", 1, hro);
		repeat (4)
		begin
			pick();
			xfer(1'b0, ahbx_pkg::HB_INCR, 1, 1'b0);
			chk("hrdata", a, rd);
			chk("hruser", exp_ruser(a), ru);
			chk("aruser", hauser, ar_user);
			chk("arprot_ns", 0, ar_prot[1]);
			chk("arprot", {~hprot[0], 1'b0, hprot[1]}, ar_prot);
			pick();
			xfer(1'b1, 3'h0, 1, 1'b0);
			chk("awuser", hauser, aw_user);
			chk("awaddr", a, aw_addr);
			chk("awprot_ns", 0, aw_prot[1]);
			chk("wstrb", 4'hf, w_strb);
			chk("wdata", wd, w_data);
			chk("wuser", hwuser, w_user);
			chk("hresp", 0, rs);
		end
		burst(1'b0, ahbx_pkg::HB_INCR, 4, 4, ahbx_pkg::LEN1);
		burst(1'b1, ahbx_pkg::HB_INCR, 3, 3, ahbx_pkg::LEN1);
		burst(1'b0, ahbx_pkg::HB_INCR8, 8, 1, ahbx_pkg::LEN8);
		chk("last_beat", a + 7, rd);
		chk("arburst", ahbx_pkg::AX_INCR, ar_burst);
		berr = 1;
		burst(1'b1, ahbx_pkg::HB_INCR8, 8, 1, ahbx_pkg::LEN8);
		chk("last_hresp", 1, rs);
		chk("early_err", 0, early);
		burst(1'b1, ahbx_pkg::HB_INCR, 1, 1, ahbx_pkg::LEN1);
		chk("single_hresp", 1, rs);
		berr = 0;
		// error on the first read beat, master drops the rest of the burst
		rresp = 2'h2;
		c0 = ar_cnt;
		pick();
		xfer(1'b0, ahbx_pkg::HB_INCR8, 1, 1'b0);
		rresp = 2'h0;
		chk("drop_hresp", 1, rs);
		// unread beats must be swallowed or this read never gets its address out
		pick();
		xfer(1'b0, 3'h0, 1, 1'b0);
		chk("after_drain", a, rd);
		chk("drop_ar_count", 2, ar_cnt - c0);
		cfg(3'h3);
		burst(1'b0, ahbx_pkg::HB_INCR8, 8, 8, ahbx_pkg::LEN1);
		burst(1'b1, ahbx_pkg::HB_INCR8, 8, 8, ahbx_pkg::LEN1);
		cfg(3'h0);
		// two locked reads in a row leave the path held
		pick();
		xfer(1'b0, 3'h0, 1, 1'b1);
		chk("arlock", 1, ar_lock);
		pick();
		xfer(1'b0, 3'h0, 1, 1'b1);
		chk("lock_held", 1, held);
		pick();
		xfer(1'b1, 3'h0, 1, 1'b0);
		chk("lock_held", 0, held);
		chk("awlock", 0, aw_lock);
		cfg(3'h4);
		pick();
		xfer(1'b0, 3'h0, 1, 1'b1);
		chk("arlock", 0, ar_lock);
		pick();
		xfer(1'b1, 3'h0, 1, 1'b0);
		finish_test();
	end
endmodule
`default_nettype wire
